// File: hw/cmb_defines.vh
/*
 * Constants for the CAN mailbox controller: register offsets, reset values
 * and field positions. Assumes inclusion by bare name from hw/ design files.
 */
`ifndef CMB_DEFINES_VH
`define CMB_DEFINES_VH

// Register offsets (word addresses on the plain register port)
`define CMB_ADDR_CANCEL 4'h0
`define CMB_ADDR_PENDING 4'h1
`define CMB_ADDR_ACK_LOW 4'h2
`define CMB_ADDR_ACK_HIGH 4'h3
`define CMB_ADDR_CTRL 4'h4
`define CMB_ADDR_STATUS 4'h5
`define CMB_ADDR_DIR_LOW 4'h6
`define CMB_ADDR_DIR_HIGH 4'h7
`define CMB_ADDR_OVW_LOW 4'h8
`define CMB_ADDR_OVW_HIGH 4'h9
`define CMB_ADDR_UNREAD_LOW 4'ha
`define CMB_ADDR_UNREAD_HIGH 4'hb
`define CMB_ADDR_RXP_LOW 4'hc
`define CMB_ADDR_RXP_HIGH 4'hd
`define CMB_ADDR_IRQF 4'he

// Reset values
`define CMB_RST_CANCEL 16'h0000
`define CMB_RST_CTRL 16'h0002

// Control register fields
`define CMB_CTRL_HALT 1
`define CMB_CTRL_SLEEP 5
`define CMB_CTRL_HALT_EN 6
`define CMB_CTRL_AUTO_WAKE 7
`define CMB_CTRL_BOFF_HALT 14

// Status register fields
`define CMB_STAT_HALT 4
`define CMB_STAT_SLEEP 5

// Interrupt flag fields
`define CMB_IRQ_DATA 1
`define CMB_IRQ_REMOTE 2

`endif

// File: hw/cmb_mailbox_ctrl.v
/*
 * CAN mailbox controller: transmit cancel and acknowledge bookkeeping, halt
 * and sleep sequencing, receive acceptance search and end-of-frame storage.
 * Assumes a CPU on the plain register port and a CAN protocol engine on the
 * same clock that pulses arbitration end, sixth EOF bit, bus-off, dominant
 * bit, transmit done and cancel done events.
 */
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "cmb_defines.vh"

module cmb_mailbox_ctrl #(
	parameter NMB = 32, // Number of mailboxes
	parameter IDW = 29 // Identifier width, 11 standard + 18 extended
) (
	input wire clk, // System clock, 50 MHz
	input wire sys_rst, // Synchronous reset, active high
	input wire [3:0] reg_addr, // Register word address
	input wire [15:0] reg_wdata, // Register write data
	input wire reg_wr, // Write strobe
	input wire reg_rd, // Read strobe
	output reg [15:0] reg_rdata, // Read data, cycle after strobe
	input wire [31:0] tx_request, // Transmit request per mailbox
	input wire [31:0] tx_done, // Pulse: mailbox transmit success
	input wire [31:0] cancel_done, // Pulse: mailbox cancellation complete
	input wire bus_off, // Pulse: protocol engine entered bus-off
	input wire dominant_seen, // Pulse: dominant bit detected on bus
	input wire bus_idle, // Level: no frame in progress
	input wire arb_end, // Pulse: end of arbitration field
	input wire [IDW-1:0] rx_id, // Received identifier
	input wire rx_ext, // Received frame uses extended identifier
	input wire rx_rtr, // Received frame is a remote frame
	input wire [3:0] rx_dlc, // Received data length
	input wire [63:0] rx_data, // Received data bytes, byte 0 low
	input wire eof6, // Pulse: sixth end-of-frame bit
	input wire [IDW-1:0] cfg_id, // Identifier of mailbox at cfg_sel
	input wire [IDW-1:0] cfg_mask, // Acceptance mask at cfg_sel, 1 = ignore
	output reg [4:0] cfg_sel, // Mailbox being searched
	output reg mb_we, // Pulse: store message into mb_num
	output reg [4:0] mb_num, // Mailbox written
	output reg [IDW-1:0] mb_id, // Identifier stored
	output reg mb_rtr, // Stored frame is remote
	output reg [3:0] mb_dlc, // Stored length
	output reg [63:0] mb_data, // Stored data, unreceived bytes zero
	output reg [31:0] transmit_cancel_request, // Cancel requests to engine
	output wire halted, // Module in halt mode
	output wire asleep // Module in sleep mode
);

	// Mode states
	localparam ST_RUN = 2'd0;
	localparam ST_HREQ = 2'd1;
	localparam ST_HALT = 2'd2;
	localparam ST_SLEEP = 2'd3;
	// Search states
	localparam SR_IDLE = 2'd0;
	localparam SR_SCAN = 2'd1;
	localparam SR_WAIT = 2'd2;

	reg [15:0] ctrl; // Control: halt, sleep, options
	reg [1:0] mode; // Current mode
	reg [31:0] transmit_acknowledge; // Acknowledge flags, high and low halves
	reg [31:0] mailbox_config; // 1 = mailbox receives
	reg [31:0] overwrite_select; // 1 = overwrite, 0 = overrun
	reg [31:0] unread_overwrite_flag; // Unread message overwritten or overrun
	reg [31:0] data_rx_pending; // Data frame stored, unread
	reg [31:0] remote_rx_pending; // Remote frame stored, unread
	reg [15:0] interrupt_request_flags; // Receive interrupt flags
	reg [1:0] srch; // Search state
	reg [4:0] hit_num; // Matching mailbox recorded
	reg [IDW-1:0] next_mb_id; // Identifier to store
	reg [63:0] next_mb_data; // Data with unreceived bytes zeroed
	wire [31:0] bus_wr_cancel; // Cancel write data widened
	wire [31:0] cancel_ok; // Cancellations accepted this write
	wire [31:0] ack_clr; // Acknowledge bits cleared by software
	integer i;

	assign halted = (mode == ST_HALT);
	assign asleep = (mode == ST_SLEEP);

	// Compare identifier under mask
	function id_match;
		input [IDW-1:0] a;
		input [IDW-1:0] b;
		input [IDW-1:0] m;
		begin
			id_match = (((a ^ b) & ~m) == {IDW{1'b0}});
		end
	endfunction

	// Decode a strobe to a given address
	function hit;
		input stb;
		input [3:0] a;
		input [3:0] want;
		begin
			hit = stb && (a == want);
		end
	endfunction

	assign bus_wr_cancel = {16'h0000, reg_wdata[15:1], 1'b0};
	assign cancel_ok = hit(reg_wr, reg_addr, `CMB_ADDR_CANCEL) ?
		(bus_wr_cancel & tx_request & ~mailbox_config) : 32'h00000000;
	assign ack_clr = {hit(reg_wr, reg_addr, `CMB_ADDR_ACK_HIGH) ? reg_wdata : 16'h0000,
		hit(reg_wr, reg_addr, `CMB_ADDR_ACK_LOW) ? reg_wdata : 16'h0000};

	// Cancel requests
	always @(posedge clk) begin
		if (sys_rst) begin
			transmit_cancel_request <= 32'h00000000;
		end else begin
			transmit_cancel_request <= ((transmit_cancel_request & ~cancel_done) | cancel_ok) &
				32'h0000fffe;
		end
	end

	// Transmit acknowledge
	always @(posedge clk) begin
		if (sys_rst) begin
			transmit_acknowledge <= 32'h00000000;
		end else begin
			transmit_acknowledge <= (transmit_acknowledge & ~ack_clr) | tx_done;
		end
	end

	// Control register and mode sequencing
	always @(posedge clk) begin
		if (sys_rst) begin
			ctrl <= `CMB_RST_CTRL;
			mode <= ST_HALT;
		end else begin
			if (hit(reg_wr, reg_addr, `CMB_ADDR_CTRL)) begin
				ctrl <= reg_wdata;
			end
			if (mode == ST_SLEEP && ctrl[`CMB_CTRL_AUTO_WAKE] && dominant_seen) begin
				ctrl[`CMB_CTRL_SLEEP] <= 1'b0;
			end
			if (bus_off && ctrl[`CMB_CTRL_BOFF_HALT] && ctrl[`CMB_CTRL_HALT_EN]) begin
				ctrl[`CMB_CTRL_HALT] <= 1'b1;
			end
			case (mode)
				ST_RUN: begin
					if (ctrl[`CMB_CTRL_HALT]) begin
						mode <= ST_HREQ;
					end
				end
				ST_HREQ: begin
					// Halt once the current frame is over
					if (bus_idle) begin
						mode <= ST_HALT;
					end
				end
				ST_HALT: begin
					if (ctrl[`CMB_CTRL_SLEEP] && !ctrl[`CMB_CTRL_HALT]) begin
						mode <= ST_SLEEP;
					end else if (!ctrl[`CMB_CTRL_HALT]) begin
						mode <= ST_RUN;
					end
				end
				ST_SLEEP: begin
					if (!ctrl[`CMB_CTRL_SLEEP] && ctrl[`CMB_CTRL_HALT]) begin
						mode <= ST_HALT;
					end else if (!ctrl[`CMB_CTRL_SLEEP]) begin
						mode <= ST_RUN;
					end
				end
				default: begin
					mode <= ST_HALT;
				end
			endcase
		end
	end

	// Stored message shaping
	always @* begin
		next_mb_id = rx_ext ? rx_id : {rx_id[IDW-1:IDW-11], {(IDW-11){1'b0}}};
		next_mb_data = 64'h0000000000000000;
		for (i = 0; i < 8; i = i + 1) begin
			if (!rx_rtr && (i < rx_dlc)) begin
				next_mb_data[i*8 +: 8] = rx_data[i*8 +: 8];
			end
		end
	end

	// Acceptance search and end-of-frame storage
	always @(posedge clk) begin
		if (sys_rst) begin
			srch <= SR_IDLE;
			cfg_sel <= 5'h1f;
			hit_num <= 5'h00;
			mb_we <= 1'b0;
			mb_num <= 5'h00;
			mb_id <= {IDW{1'b0}};
			mb_rtr <= 1'b0;
			mb_dlc <= 4'h0;
			mb_data <= 64'h0000000000000000;
			unread_overwrite_flag <= 32'h00000000;
			data_rx_pending <= 32'h00000000;
			remote_rx_pending <= 32'h00000000;
			interrupt_request_flags <= 16'h0000;
		end else begin
			mb_we <= 1'b0;
			// Software write-one clears of receive flags
			if (hit(reg_wr, reg_addr, `CMB_ADDR_UNREAD_LOW)) begin
				unread_overwrite_flag[15:0] <= unread_overwrite_flag[15:0] & ~reg_wdata;
			end
			if (hit(reg_wr, reg_addr, `CMB_ADDR_UNREAD_HIGH)) begin
				unread_overwrite_flag[31:16] <= unread_overwrite_flag[31:16] & ~reg_wdata;
			end
			if (hit(reg_wr, reg_addr, `CMB_ADDR_RXP_LOW)) begin
				data_rx_pending[15:0] <= data_rx_pending[15:0] & ~reg_wdata;
				remote_rx_pending[15:0] <= remote_rx_pending[15:0] & ~reg_wdata;
			end
			if (hit(reg_wr, reg_addr, `CMB_ADDR_RXP_HIGH)) begin
				data_rx_pending[31:16] <= data_rx_pending[31:16] & ~reg_wdata;
				remote_rx_pending[31:16] <= remote_rx_pending[31:16] & ~reg_wdata;
			end
			if (hit(reg_wr, reg_addr, `CMB_ADDR_IRQF)) begin
				interrupt_request_flags <= interrupt_request_flags & ~reg_wdata;
			end
			case (srch)
				SR_IDLE: begin
					if (arb_end && mode == ST_RUN) begin
						srch <= SR_SCAN;
						cfg_sel <= 5'h1f;
					end
				end
				SR_SCAN: begin
					if (mailbox_config[cfg_sel] && id_match(rx_id, cfg_id, cfg_mask)) begin
						hit_num <= cfg_sel;
						srch <= SR_WAIT;
					end else if (cfg_sel == 5'h00) begin
						srch <= SR_IDLE;
					end else begin
						cfg_sel <= cfg_sel - 5'h01;
					end
				end
				SR_WAIT: begin
					if (eof6) begin
						srch <= SR_IDLE;
						if (data_rx_pending[hit_num] || remote_rx_pending[hit_num]) begin
							unread_overwrite_flag[hit_num] <= 1'b1;
						end
						if (overwrite_select[hit_num] ||
							!(data_rx_pending[hit_num] || remote_rx_pending[hit_num])) begin
							mb_we <= 1'b1;
							mb_num <= hit_num;
							mb_id <= next_mb_id;
							mb_rtr <= rx_rtr;
							mb_dlc <= rx_dlc;
							mb_data <= next_mb_data;
							if (rx_rtr) begin
								remote_rx_pending[hit_num] <= 1'b1;
								interrupt_request_flags[`CMB_IRQ_REMOTE] <= 1'b1;
							end else begin
								data_rx_pending[hit_num] <= 1'b1;
								interrupt_request_flags[`CMB_IRQ_DATA] <= 1'b1;
							end
							if (!rx_rtr && remote_rx_pending[hit_num]) begin
								interrupt_request_flags[`CMB_IRQ_REMOTE] <= 1'b1;
								remote_rx_pending[hit_num] <= 1'b1;
							end
							if (rx_rtr && data_rx_pending[hit_num]) begin
								interrupt_request_flags[`CMB_IRQ_DATA] <= 1'b1;
							end
						end
					end
				end
				default: begin
					srch <= SR_IDLE;
				end
			endcase
		end
	end

	// Mailbox configuration, written only while halted
	always @(posedge clk) begin
		if (sys_rst) begin
			mailbox_config <= 32'h00000001;
			overwrite_select <= 32'h00000000;
		end else if (halted) begin
			if (hit(reg_wr, reg_addr, `CMB_ADDR_DIR_LOW)) begin
				mailbox_config[15:0] <= reg_wdata | 16'h0001;
			end
			if (hit(reg_wr, reg_addr, `CMB_ADDR_DIR_HIGH)) begin
				mailbox_config[31:16] <= reg_wdata;
			end
			if (hit(reg_wr, reg_addr, `CMB_ADDR_OVW_LOW)) begin
				overwrite_select[15:0] <= reg_wdata;
			end
			if (hit(reg_wr, reg_addr, `CMB_ADDR_OVW_HIGH)) begin
				overwrite_select[31:16] <= reg_wdata;
			end
		end
	end

	// Read data, one cycle after the strobe, zero otherwise
	always @(posedge clk) begin
		if (sys_rst || !reg_rd) begin
			reg_rdata <= 16'h0000;
		end else begin
			case (reg_addr)
				`CMB_ADDR_CANCEL: reg_rdata <= transmit_cancel_request[15:0];
				`CMB_ADDR_PENDING: reg_rdata <= tx_request[15:0];
				`CMB_ADDR_ACK_LOW: reg_rdata <= transmit_acknowledge[15:0];
				`CMB_ADDR_ACK_HIGH: reg_rdata <= transmit_acknowledge[31:16];
				`CMB_ADDR_CTRL: reg_rdata <= ctrl;
				`CMB_ADDR_STATUS: reg_rdata <= {10'h000, asleep, halted, 4'h0};
				`CMB_ADDR_DIR_LOW: reg_rdata <= mailbox_config[15:0];
				`CMB_ADDR_DIR_HIGH: reg_rdata <= mailbox_config[31:16];
				`CMB_ADDR_OVW_LOW: reg_rdata <= overwrite_select[15:0];
				`CMB_ADDR_OVW_HIGH: reg_rdata <= overwrite_select[31:16];
				`CMB_ADDR_UNREAD_LOW: reg_rdata <= unread_overwrite_flag[15:0];
				`CMB_ADDR_UNREAD_HIGH: reg_rdata <= unread_overwrite_flag[31:16];
				`CMB_ADDR_RXP_LOW: reg_rdata <= data_rx_pending[15:0] | remote_rx_pending[15:0];
				`CMB_ADDR_RXP_HIGH: reg_rdata <= data_rx_pending[31:16] | remote_rx_pending[31:16];
				`CMB_ADDR_IRQF: reg_rdata <= interrupt_request_flags;
				default: reg_rdata <= 16'h0000;
			endcase
		end
	end

endmodule

// File: sim/cmb_engine_model.sv
/* Protocol engine stand-in: frames, events and the mailbox id/mask table.
   Assumes the bench fills the table and calls the tasks. */
`timescale 1ns/1ps
module cmb_engine_model (
	input wire clk, // System clock
	input wire [4:0] cfg_sel, // Mailbox searched
	output wire [28:0] cfg_id, // Its identifier
	output wire [28:0] cfg_mask, // Its mask
	output reg arb_end, // Arbitration end
	output reg eof6, // Sixth EOF bit
	output reg bus_idle, // No frame running
	output reg bus_off, // Bus-off event
	output reg dominant_seen, // Dominant bit event
	output reg [28:0] rx_id, // Frame identifier
	output reg rx_ext, // Extended frame
	output reg rx_rtr, // Remote frame
	output reg [3:0] rx_dlc, // Data length
	output reg [63:0] rx_data, // Data bytes
	output reg [31:0] tx_done, // Transmit success
	output reg [31:0] cancel_done // Cancel complete
);
	reg [28:0] mid [0:31]; // Mailbox identifiers
	reg [28:0] mmask [0:31]; // Mailbox masks
	assign cfg_id = mid[cfg_sel];
	assign cfg_mask = mmask[cfg_sel];
	initial begin
		{arb_end, eof6, bus_off, dominant_seen, rx_ext, rx_rtr, rx_dlc} = 10'h000;
		bus_idle = 1'b1;
		{rx_id, rx_data, tx_done, cancel_done} = 157'h0;
	end
	// Released frame lines keep changing so stale values never match
	always @(posedge clk) if (bus_idle) begin
		rx_id <= ~rx_id;
		rx_data <= ~rx_data;
	end
	// One frame, fields steady from arbitration end to EOF
	task frame(input [28:0] id, input x, input r, input [3:0] n, input [63:0] d);
		@(posedge clk) bus_idle <= 1'b0;
		@(posedge clk);
		{rx_id, rx_ext, rx_rtr, rx_dlc, rx_data} <= {id, x, r, n, d};
		arb_end <= 1'b1;
		@(posedge clk) arb_end <= 1'b0;
		repeat (40) @(posedge clk);
		eof6 <= 1'b1;
		@(posedge clk) eof6 <= 1'b0;
		@(posedge clk) bus_idle <= 1'b1;
	endtask
	// One-cycle event pulses
	task pulse(input [31:0] t, input [31:0] c, input bo, input dom);
		@(posedge clk);
		{tx_done, cancel_done, bus_off, dominant_seen} <= {t, c, bo, dom};
		@(posedge clk);
		{tx_done, cancel_done, bus_off, dominant_seen} <= 66'h0;
	endtask
endmodule

// File: sim/cmb_mailbox_ctrl_monitor.sv
/* Port checker for the CAN mailbox controller.
   Assumes binding to cmb_mailbox_ctrl, one clock, synchronous reset. */
`timescale 1ns/1ps
module cmb_mailbox_ctrl_monitor #(
	parameter NMB = 32, // Mailbox count
	parameter IDW = 29 // Identifier width
) (
	input wire clk, // System clock
	input wire sys_rst, // Reset, high
	input wire [3:0] reg_addr, // Register address
	input wire reg_wr, // Write strobe
	input wire [31:0] tx_request, // Transmit pending
	input wire [31:0] cancel_done, // Cancel complete
	input wire rx_ext, // Extended frame
	input wire eof6, // Sixth EOF bit
	input wire mb_we, // Store strobe
	input wire [IDW-1:0] mb_id, // Stored identifier
	input wire mb_rtr, // Stored remote frame
	input wire [63:0] mb_data, // Stored data
	input wire [31:0] transmit_cancel_request, // Cancel requests
	input wire halted, // Halt mode
	input wire asleep // Sleep mode
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_cancel_range: assert property (
		transmit_cancel_request[0] == 1'b0 && transmit_cancel_request[31:16] == 16'h0)
		else $error("cancel request outside mailboxes 15..1");
	a_cancel_cause: assert property (
		!$past(sys_rst) && |(transmit_cancel_request & ~$past(transmit_cancel_request))
		|-> $past(reg_wr) && $past(reg_addr) == 4'h0) else $error("cancel set without a write");
	a_cancel_pend: assert property (
		!$past(sys_rst) |-> (transmit_cancel_request & ~$past(transmit_cancel_request)
		& ~$past(tx_request)) == 32'h0) else $error("cancel set on idle mailbox");
	a_cancel_hold: assert property (
		!$past(sys_rst) |-> ($past(transmit_cancel_request) & ~transmit_cancel_request
		& ~$past(cancel_done)) == 32'h0) else $error("cancel dropped early");
	a_cancel_clear: assert property (
		|(cancel_done & transmit_cancel_request) && !(reg_wr && reg_addr == 4'h0)
		|=> (transmit_cancel_request & $past(cancel_done)) == 32'h0) else $error("cancel not cleared");
	a_store_timing: assert property (
		mb_we |-> $past(eof6) && !$past(mb_we)) else $error("store not one cycle after EOF");
	a_std_extended_identifier: assert property (
		mb_we && !$past(rx_ext) |-> mb_id[17:0] == 18'h0) else $error("standard frame extended id kept");
	a_remote_zero: assert property (
		mb_we && mb_rtr |-> mb_data == 64'h0) else $error("remote frame stored data");
	c_store: cover property (mb_we);
	c_cancel: cover property (transmit_cancel_request != 32'h0);
	c_sleep: cover property ($rose(asleep));
	c_run: cover property ($fell(halted));
endmodule
bind cmb_mailbox_ctrl cmb_mailbox_ctrl_monitor #(.NMB(NMB), .IDW(IDW)) mon_u (.clk, .sys_rst, .reg_addr,
	.reg_wr, .tx_request, .cancel_done, .rx_ext, .eof6, .mb_we, .mb_id, .mb_rtr, .mb_data,
	.transmit_cancel_request, .halted, .asleep);

// File: sim/cmb_mailbox_ctrl_tb_top.sv
/* Self-checking bench for the CAN mailbox controller.
   Assumes cmb_engine_model on the far side and the bound port checker. */
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; \
	$display("[FAIL] %0t got %h want %h", $time, g, e); end end
module cmb_mailbox_ctrl_tb_top;
	typedef struct {int n; logic [28:0] id; logic [63:0] d; logic r; logic [3:0] l;} cmb_exp_t;
	logic clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0; // Clock, reset, strobes
	logic [3:0] reg_addr = 0; // Register address
	logic [15:0] reg_wdata = 0; // Write data
	logic [31:0] tx_request = 0, t; // Transmit pending, scratch
	wire [15:0] reg_rdata;
	wire [4:0] cfg_sel, mb_num;
	wire [28:0] cfg_id, cfg_mask, rx_id, mb_id;
	wire [3:0] rx_dlc, mb_dlc;
	wire [63:0] rx_data, mb_data;
	wire [31:0] tx_done, cancel_done, transmit_cancel_request;
	wire arb_end, eof6, bus_idle, bus_off, dominant_seen, rx_ext, rx_rtr, mb_we, mb_rtr, halted, asleep;
	int n_errors = 0, compares = 0;
	cmb_exp_t q[$], e; // Expected stores
	// Reference state: receive map, overwrite map, flags
	logic [31:0] dir = 32'h8000_0031, ovw = 32'h10, pend = 0, kind = 0, unr = 0;
	logic [15:0] irq = 0;
	always #10 clk = ~clk;
	cmb_mailbox_ctrl dut_u (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .tx_request,
		.tx_done, .cancel_done, .bus_off, .dominant_seen, .bus_idle, .arb_end, .rx_id, .rx_ext, .rx_rtr,
		.rx_dlc, .rx_data, .eof6, .cfg_id, .cfg_mask, .cfg_sel, .mb_we, .mb_num, .mb_id, .mb_rtr,
		.mb_dlc, .mb_data, .transmit_cancel_request, .halted, .asleep);
	cmb_engine_model eng_u (.clk, .cfg_sel, .cfg_id, .cfg_mask, .arb_end, .eof6, .bus_idle, .bus_off,
		.dominant_seen, .rx_id, .rx_ext, .rx_rtr, .rx_dlc, .rx_data, .tx_done, .cancel_done);
	// Compare every store against the reference queue
	always @(posedge clk) if (mb_we === 1'b1) begin
		if (q.size() == 0) begin
			n_errors++;
			$display("[FAIL] %0t store not expected", $time);
		end else begin
			e = q.pop_front();
			`CHK(mb_num, e.n[4:0])
			`CHK(mb_id, e.id)
			`CHK(mb_data, e.d)
			`CHK(mb_rtr, e.r)
			`CHK(mb_dlc, e.l)
		end
	end
	task wr(input [3:0] a, input [15:0] d);
		@(posedge clk);
		{reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
		@(posedge clk) reg_wr <= 1'b0;
	endtask
	task rd(input [3:0] a, input [15:0] x);
		@(posedge clk);
		{reg_addr, reg_rd} <= {a, 1'b1};
		@(posedge clk) reg_rd <= 1'b0;
		#1 `CHK(reg_rdata, x)
	endtask
	// Wait, bounded, for a halt and sleep state
	task wmode(input h, input s);
		for (int k = 0; k < 20 && {halted, asleep} !== {h, s}; k++) @(posedge clk);
		#1 `CHK({halted, asleep}, {h, s})
	endtask
	// Data kept only for received bytes of data frames
	function [63:0] keep(input [3:0] n, input r, input [63:0] d);
		for (int i = 0; i < 8; i++) if (r || i >= n) d[8*i+:8] = 8'h0;
		return d;
	endfunction
	// Reference search from mailbox 31 down, then send the frame
	task rx(input [28:0] id, input x, input r, input [3:0] n);
		int w;
		w = -1;
		for (int i = 31; i >= 0 && w < 0; i--)
			if (dir[i] && ((id ^ eng_u.mid[i]) & ~eng_u.mmask[i]) == 29'h0) w = i;
		if (w >= 0) begin
			if (pend[w]) unr[w] = 1'b1;
			if (!pend[w] || ovw[w]) begin
				t = $urandom;
				q.push_back('{w, x ? id : {id[28:18], 18'h0}, keep(n, r, {t, ~t}), r, n});
				irq = irq | (r ? 16'h4 : 16'h2) | ((pend[w] && kind[w] != r) ? 16'h6 : 16'h0);
				pend[w] = 1'b1;
				kind[w] = r;
			end
		end
		eng_u.frame(id, x, r, n, {t, ~t});
		repeat (2) @(posedge clk);
	endtask
	task test_done;
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge clk);
		n_errors++;
		$display("[FAIL] %0t run too long", $time);
		test_done;
	end
	initial begin
		void'($urandom(32'h48c38103));
		for (int i = 0; i < 32; i++) {eng_u.mid[i], eng_u.mmask[i]} = {29'h1fffffff, 29'h0};
		{eng_u.mid[31], eng_u.mmask[31], eng_u.mmask[4], eng_u.mid[5]} = {29'h5540000, 29'h3ffff, ~29'h0, 29'ha5a5a5};
		repeat (4) @(posedge clk);
		sys_rst <= 1'b0;
		rd(4'h0, 16'h0);
		rd(4'h4, 16'h0002);
		rd(4'h5, 16'h0010);
		rd(4'hf, 16'h0);
		wr(4'h6, dir[15:0]);
		wr(4'h7, dir[31:16]);
		wr(4'h8, ovw[15:0]);
		wr(4'h9, 16'h0);
		rd(4'h7, dir[31:16]);
		wr(4'h4, 16'h0);
		wmode(0, 0);
		tx_request <= $urandom | 32'h0000ff00;
		wr(4'h0, 16'hffff);
		rd(4'h0, 16'hfffe & tx_request[15:0] & ~dir[15:0]);
		eng_u.pulse(0, {16'h0, 16'hfffe & tx_request[15:0] & ~dir[15:0]}, 0, 0);
		rd(4'h0, 16'h0);
		t = $urandom;
		eng_u.pulse(t, 0, 0, 0);
		rd(4'h2, t[15:0]);
		fork
			wr(4'h2, 16'hffff);
			eng_u.pulse(32'h8, 0, 0, 0);
		join
		rd(4'h2, 16'h0008);
		wr(4'h3, 16'h0);
		rd(4'h3, t[31:16]);
		rx(29'h556a5a5, 0, 0, 3);
		rx(29'h0a5a5a5, 1, 0, 8);
		rx(29'h0a5a5a5, 1, 1, 0);
		rx(29'h1234567, 1, 0, 9);
		rx(29'h1234567, 1, 1, 2);
		rx(29'h1234567, 1, 0, 1);
		rd(4'ha, unr[15:0]);
		rd(4'hc, pend[15:0]);
		rd(4'hd, pend[31:16]);
		rd(4'he, irq);
		wr(4'hc, 16'hffff);
		rd(4'hc, 16'h0);
		wr(4'h4, 16'h4040);
		eng_u.pulse(0, 0, 1, 0);
		rd(4'h4, 16'h4042);
		wmode(1, 0);
		wr(4'h4, 16'h40e0);
		wmode(0, 1);
		wr(4'h4, 16'h40c2);
		wmode(1, 0);
		wr(4'h4, 16'h40e0);
		wmode(0, 1);
		eng_u.pulse(0, 0, 0, 1);
		rd(4'h4, 16'h40c0);
		wmode(0, 0);
		`CHK(q.size(), 0)
		test_done;
	end
endmodule
